/* File: src/scd_pkg.sv */
/*
 * Package for the system clock divider and oscillator trim block:
 * register indices and addresses, field positions, reset codes, the
 * unlock timeout and the register layout types.
 * Assumes a 32-bit APB with one aligned word per register.
 */
package scd_pkg;

	// Register indices as printed, byte address is four times the index
	localparam logic [7:0]  SCD_DIVCTL_INDEX   = 8'h26;
	localparam logic [7:0]  SCD_TRIM_INDEX     = 8'h31;
	localparam logic [11:0] SCD_DIVCTL_ADDR    = {2'h0, SCD_DIVCTL_INDEX, 2'h0};
	localparam logic [11:0] SCD_TRIM_ADDR      = {2'h0, SCD_TRIM_INDEX, 2'h0};

	// Field positions of clock_divide_control and of the oscillator trim register
	localparam int          SCD_UNLOCK_BIT     = 7;
	localparam int          SCD_SELECT_MSB     = 3;
	localparam int          SCD_TRIM_RANGE_BIT = 7;

	// Reset values
	localparam logic [3:0]  SCD_SELECT_RESET_UNPROG = 4'h0;
	localparam logic [3:0]  SCD_SELECT_RESET_DIV8   = 4'h3;
	localparam logic [7:0]  SCD_TRIM_RESET          = 8'h00;

	// Highest defined select code (divide by 256); codes above are reserved
	localparam logic [3:0]  SCD_SELECT_MAX     = 4'h8;

	// Unlock write pattern and timeout in divided system clock cycles
	localparam logic [7:0]  SCD_UNLOCK_PATTERN = 8'h80;
	localparam int          SCD_UNLOCK_CYCLES  = 4;
	localparam logic [2:0]  SCD_UNLOCK_LAST    = 3'(SCD_UNLOCK_CYCLES - 1);

	typedef struct packed {
		logic       unlock;
		logic [2:0] reserved;
		logic [3:0] select;
	} scd_divctl_type;

	typedef struct packed {
		logic       range_select;
		logic [6:0] fine_value;
	} scd_trim_type;

endpackage : scd_pkg

/* File: src/scd_rate_gen.sv */
/*
 * Power-of-two rate generator: gives a one-cycle enable pulse every
 * 2^code cycles of the undivided clock, 256 cycles for codes above 8.
 * Assumes the requested code may change at any time; it is adopted only
 * at the end of a whole period so no shortened period appears.
 */
`timescale 1ns/1ps
`default_nettype none

module scd_rate_gen
	import scd_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] req_code,
	output var  logic [3:0] active_code,
	output var  logic       tick
);

	logic [7:0] count;
	logic [7:0] next_count;
	logic [3:0] next_active_code;
	logic       next_tick;
	logic       period_end;

	// Last count of a period; reserved codes saturate at divide by 256
	function automatic logic [7:0] scd_limit(input logic [3:0] code);
		logic [3:0] c;
		c = (code > SCD_SELECT_MAX) ? SCD_SELECT_MAX : code;
		scd_limit = 8'((9'h001 << c) - 9'h001);
	endfunction : scd_limit

	always_comb begin
		period_end       = (count == scd_limit(active_code));
		next_count       = period_end ? 8'h00 : 8'(count + 8'h01);
		// New rate starts only after the old period has completed
		next_active_code = period_end ? req_code : active_code;
		next_tick        = period_end;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count       <= 8'h00;
			active_code <= 4'h0;
			tick        <= 1'b0;
		end else begin
			count       <= next_count;
			active_code <= next_active_code;
			tick        <= next_tick;
		end
	end

endmodule : scd_rate_gen

`default_nettype wire

/* File: src/scd_top.sv */
/*
 * System clock divider and oscillator trim: APB slave holding the
 * oscillator trim register and the clock divide control register with
 * its timed unlock, plus the system clock enable generator.
 * Assumes APB master signals synchronous to pclk, factory trim and fuse
 * inputs stable from reset onward, and no access in the first cycle
 * after reset release.
 */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module scd_top
	import scd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [7:0]  factory_trim,
	input  wire logic        div8_fuse_programmed,
	output var  logic [7:0]  trim_value,
	output var  logic        trim_range_select,
	output var  logic [6:0]  trim_fine_value,
	output var  logic [3:0]  divider_active,
	output var  logic        sys_clk_en
);

	// Register state
	scd_trim_type   trim;
	scd_trim_type   next_trim;
	scd_divctl_type divctl;
	scd_divctl_type next_divctl;
	logic [2:0]     unlock_count;
	logic [2:0]     next_unlock_count;
	logic           load_pending;
	logic           next_load_pending;

	// APB answer state
	logic [31:0]    next_prdata;
	logic           next_pready;
	logic           next_pslverr;

	// Output copies
	logic [7:0]     next_trim_value;
	logic           next_trim_range_select;
	logic [6:0]     next_trim_fine_value;

	// Decode
	logic           setup_phase;
	logic           access_done;
	logic           hit_divctl;
	logic           hit_trim;
	logic           wr_divctl;
	logic           wr_trim;
	logic [7:0]     wbyte;
	logic           sys_tick;
	logic [3:0]     rate_code;

	function automatic logic scd_mapped(input logic [11:0] addr);
		scd_mapped = (addr == SCD_DIVCTL_ADDR) || (addr == SCD_TRIM_ADDR);
	endfunction : scd_mapped

	// Bus decode
	always_comb begin
		setup_phase = psel && !penable;
		access_done = psel && penable && pready;
		hit_divctl  = (paddr == SCD_DIVCTL_ADDR);
		hit_trim    = (paddr == SCD_TRIM_ADDR);
		wr_divctl   = access_done && pwrite && hit_divctl;
		wr_trim     = access_done && pwrite && hit_trim;
		wbyte       = pwdata[7:0];
	end

	// APB answer: zero wait states, answer in the first access cycle
	always_comb begin
		next_pready  = setup_phase;
		next_pslverr = setup_phase && !scd_mapped(paddr);
		next_prdata  = 32'h0000_0000;
		if (setup_phase && !pwrite) begin
			if (hit_divctl) begin
				// Reserved bits of the divider word always read zero
				next_prdata = {24'h00_0000, divctl.unlock, 3'h0, divctl.select};
			end else if (hit_trim) begin
				next_prdata = {24'h00_0000, trim};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// Oscillator trim register
	always_comb begin
		next_trim         = trim;
		next_load_pending = 1'b0;
		if (load_pending) begin
			// Factory value is caught on the first edge after release
			next_trim = factory_trim;
		end else if (wr_trim) begin
			next_trim = wbyte;
		end
		// Range bit and fine field go straight to the oscillator
		next_trim_value        = next_trim;
		next_trim_range_select = next_trim.range_select;
		next_trim_fine_value   = next_trim.fine_value;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim              <= SCD_TRIM_RESET;
			load_pending      <= 1'b1;
			trim_value        <= SCD_TRIM_RESET;
			trim_range_select <= 1'b0;
			trim_fine_value   <= 7'h00;
		end else begin
			trim              <= next_trim;
			load_pending      <= next_load_pending;
			trim_value        <= next_trim_value;
			trim_range_select <= next_trim_range_select;
			trim_fine_value   <= next_trim_fine_value;
		end
	end

	// Clock divide control with timed unlock
	always_comb begin
		next_divctl          = divctl;
		next_divctl.reserved = 3'h0;
		next_unlock_count    = unlock_count;
		if (load_pending) begin
			next_divctl.select = div8_fuse_programmed ? SCD_SELECT_RESET_DIV8
			                                          : SCD_SELECT_RESET_UNPROG;
		end else begin
			// Timeout runs on divided system cycles after the unlock write
			if (divctl.unlock && sys_tick) begin
				if (unlock_count == SCD_UNLOCK_LAST) begin
					next_divctl.unlock = 1'b0;
					next_unlock_count  = 3'h0;
				end else begin
					next_unlock_count = 3'(unlock_count + 3'h1);
				end
			end
			if (wr_divctl) begin
				if (wbyte == SCD_UNLOCK_PATTERN) begin
					// A rewrite while open leaves flag and count alone
					if (!divctl.unlock) begin
						next_divctl.unlock = 1'b1;
						next_unlock_count  = 3'h0;
					end
				end else if (!wbyte[SCD_UNLOCK_BIT]) begin
					if (divctl.unlock) begin
						// Any code accepted, fuse only set the reset value
						next_divctl.select = wbyte[SCD_SELECT_MSB:0];
					end
					next_divctl.unlock = 1'b0;
					next_unlock_count  = 3'h0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divctl       <= '0;
			unlock_count <= 3'h0;
		end else begin
			divctl       <= next_divctl;
			unlock_count <= next_unlock_count;
		end
	end

	// System clock enable generator
	// Rate switches only at a period boundary, giving old then new period
	scd_rate_gen u_rate_gen (
		.pclk        (pclk),
		.presetn     (presetn),
		.req_code    (divctl.select),
		.active_code (rate_code),
		.tick        (sys_tick)
	);

	always_comb begin
		sys_clk_en     = sys_tick;
		divider_active = rate_code;
	end

endmodule : scd_top

`default_nettype wire

/* File: dv/scd_top_sva.sv */
/* Checker on scd_top ports: APB answer timing, trim and divider effects.
   Assumes the single pclk domain and active-low presetn. */
`timescale 1ns/1ps
`default_nettype none
module scd_top_sva
	import scd_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  factory_trim,
	input wire logic        div8_fuse_programmed,
	input wire logic [7:0]  trim_value,
	input wire logic        trim_range_select,
	input wire logic [6:0]  trim_fine_value,
	input wire logic [3:0]  divider_active,
	input wire logic        sys_clk_en
);
	logic acc;
	logic twr;
	assign acc = psel && penable && pready;
	assign twr = acc && pwrite && paddr == SCD_TRIM_ADDR;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_first: assert property (psel && !penable |=> pready) else $error("late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("long");
	a_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("err");
	a_unmapped_err:
		assert property (acc && paddr != SCD_TRIM_ADDR && paddr != SCD_DIVCTL_ADDR |-> pslverr)
		else $error("no err");
	a_rsvd_zero:
		assert property (acc && !pwrite && paddr == SCD_DIVCTL_ADDR |->
			prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0) else $error("rsvd");
	a_trim_write:
		assert property (twr |=> trim_value == $past(pwdata[7:0])) else $error("trim");
	a_trim_split:
		assert property (trim_range_select == trim_value[7] && trim_fine_value == trim_value[6:0])
		else $error("split");
	a_trim_hold:
		assert property ($changed(trim_value) && $past(presetn, 2) |-> $past(twr))
		else $error("hold");
	a_div_at_tick:
		assert property ($changed(divider_active) && $past(presetn, 2) |->
			sys_clk_en || $past(sys_clk_en)) else $error("glitch");
endmodule : scd_top_sva
bind scd_top scd_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .factory_trim(factory_trim),
	.div8_fuse_programmed(div8_fuse_programmed), .trim_value(trim_value),
	.trim_range_select(trim_range_select), .trim_fine_value(trim_fine_value),
	.divider_active(divider_active), .sys_clk_en(sys_clk_en));
`default_nettype wire

/* File: dv/scd_top_tb_top.sv */
/* Testbench for scd_top: register rows, unlock timing, divider sweep, reset.
   Assumes nothing around it; drives APB, fuse and factory trim itself. */
`timescale 1ns/1ps
`default_nettype none
module scd_top_tb_top
	import scd_pkg::*;
;
	typedef struct packed {
		logic        wr;
		logic [11:0] a;
		logic [7:0]  d;
		logic [7:0]  e;
		logic        err;
	} scd_row_type;
	localparam logic [11:0] T = SCD_TRIM_ADDR;
	localparam logic [11:0] D = SCD_DIVCTL_ADDR;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fuse, sys_clk_en, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  ftrim, tval;
	logic        trng;
	logic [6:0]  tfine;
	logic [3:0]  divider_active;
	int          fail_count, num_checks, cyc, n, i;
	scd_row_type rows [15];
	scd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .factory_trim(ftrim), .div8_fuse_programmed(fuse),
		.trim_value(tval), .trim_range_select(trng), .trim_fine_value(tfine),
		.divider_active(divider_active), .sys_clk_en(sys_clk_en));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wp;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (sys_clk_en !== 1'b1);
	endtask : wp
	task automatic rst(input logic f, input logic [7:0] t);
		presetn <= 1'b0;
		fuse <= f;
		ftrim <= t;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask : rst
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		// Trim writes set and clear the range bit; divider writes are tried locked and after unlock; last row is unmapped
		rows = '{'{1'b0, T, 8'h00, 8'ha5, 1'b0}, '{1'b0, D, 8'h00, 8'h03, 1'b0},
			'{1'b1, T, 8'h85, 8'h00, 1'b0},
			'{1'b1, T, 8'h7f, 8'h00, 1'b0}, '{1'b0, T, 8'h00, 8'h7f, 1'b0},
			'{1'b1, T, 8'h80, 8'h00, 1'b0}, '{1'b0, T, 8'h00, 8'h80, 1'b0},
			'{1'b1, D, 8'h05, 8'h00, 1'b0}, '{1'b0, D, 8'h00, 8'h03, 1'b0},
			'{1'b1, D, 8'h81, 8'h00, 1'b0}, '{1'b0, D, 8'h00, 8'h03, 1'b0},
			'{1'b1, D, 8'h80, 8'h00, 1'b0}, '{1'b1, D, 8'h75, 8'h00, 1'b0},
			'{1'b0, D, 8'h00, 8'h05, 1'b0}, '{1'b0, 12'h000, 8'h00, 8'h00, 1'b1}};
		rst(1'b1, 8'ha5);
		foreach (rows[k]) begin
			apb(rows[k].wr, rows[k].a, rows[k].d);
			chk({31'h0, err}, {31'h0, rows[k].err});
			if (!rows[k].wr)
				chk(rd, {24'h0, rows[k].e});
			if (!rows[k].wr && rows[k].a == T) begin
				chk({24'h0, tval}, {24'h0, rows[k].e});
				chk({24'h0, trng, tfine}, {24'h0, rows[k].e});
			end
		end
		$display("register rows done");
		wp();
		apb(1, D, 8'h80);
		apb(0, D, 8'h00);
		chk(rd, 32'h85);
		repeat (5) wp();
		apb(0, D, 8'h00);
		chk(rd, 32'h05);
		apb(1, D, 8'h02);
		apb(0, D, 8'h00);
		chk(rd, 32'h05);
		wp();
		apb(1, D, 8'h80);
		wp();
		apb(1, D, 8'h80);
		apb(0, D, 8'h00);
		chk(rd, 32'h85);
		repeat (3) wp();
		apb(0, D, 8'h00);
		chk(rd, 32'h05);
		$display("unlock timing done");
		for (i = 0; i < 9; i++) begin
			apb(1, D, 8'h80);
			apb(1, D, 8'(i));
			wp();
			chk(32'(n <= (i == 0 ? 32 : 1 << (i - 1))), 32'h1);
			repeat (2) wp();
			chk(32'(n), 32'h1 << i);
			chk({28'h0, divider_active}, 32'(i));
		end
		// Reserved code is stored and read back, divider saturates at 256
		apb(1, D, 8'h80);
		apb(1, D, 8'h0c);
		apb(0, D, 8'h00);
		chk(rd, 32'h0c);
		repeat (3) wp();
		chk(32'(n), 32'h100);
		chk({28'h0, divider_active}, 32'hc);
		$display("divider sweep done");
		rst(1'b0, 8'h3c);
		apb(0, T, 8'h00);
		chk(rd, 32'h3c);
		apb(0, D, 8'h00);
		chk(rd, 32'h00);
		repeat (2) wp();
		chk(32'(n), 32'h1);
		$display("reset done");
		print_verdict();
	end
endmodule : scd_top_tb_top
`default_nettype wire
